// ===== hw/uart_irq_regs.svh
// Register offsets, field positions, reset values and counts
`ifndef UART_IRQ_REGS_SVH
`define UART_IRQ_REGS_SVH

`define UART_INTEN_OFS      12'h004
`define UART_IDENT_OFS      12'h008
`define UART_FCTL_OFS       12'h008

`define UART_IDENT_RESET    32'h0000_0001
`define UART_FCTL_RESET     32'h0000_0000
`define UART_FCTL_EN_RESET  1'b0
`define UART_INTEN_RESET    8'h00

`define UART_INTEN_RDA_BIT  0
`define UART_INTEN_THRE_BIT 1
`define UART_INTEN_LS_BIT   2
`define UART_INTEN_MS_BIT   3
`define UART_INTEN_THM_BIT  7
`define UART_INTEN_MASK     8'h8F

`define UART_FCTL_EN_BIT    0
`define UART_FCTL_RXCLR_BIT 1
`define UART_FCTL_TXCLR_BIT 2
`define UART_FCTL_TXT_LSB   4
`define UART_FCTL_RXT_LSB   6

`define UART_FIFO_DEPTH     5'd16
`define UART_RX_TRIG0       5'd1
`define UART_RX_TRIG1       5'd4
`define UART_RX_TRIG2       5'd8
`define UART_RX_TRIG3       5'd14
`define UART_TX_THR0        5'd0
`define UART_TX_THR1        5'd2
`define UART_TX_THR2        5'd4
`define UART_TX_THR3        5'd8

`define UART_TIMEOUT_CHARS  3'd4

`endif

// ===== hw/uart_irq_pkg.sv
// Types shared by the interrupt identity and FIFO control logic
package uart_irq_pkg;

   typedef enum logic [3:0] {
      ID_MODEM   = 4'h0,
      ID_NONE    = 4'h1,
      ID_THRE    = 4'h2,
      ID_RDA     = 4'h4,
      ID_LINE    = 4'h6,
      ID_BUSY    = 4'h7,
      ID_TIMEOUT = 4'hC
   } irq_id_type;

   typedef logic [1:0] level_sel_type;

endpackage : uart_irq_pkg

// ===== hw/fifo_level_cmp.sv
// Compares a FIFO fill level with one of four selectable thresholds
`timescale 1ns/1ps
module fifo_level_cmp
   import uart_irq_pkg::*;
#(
   parameter logic [4:0] LVL0     = 5'd0,
   parameter logic [4:0] LVL1     = 5'd0,
   parameter logic [4:0] LVL2     = 5'd0,
   parameter logic [4:0] LVL3     = 5'd0,
   parameter bit         AT_ABOVE = 1'b1
) (
   input  wire level_sel_type sel,
   input  wire logic [4:0]    level,
   output wire logic          hit
);

   wire logic [4:0] limit;

   assign limit = (sel == 2'h0) ? LVL0 :
                  (sel == 2'h1) ? LVL1 :
                  (sel == 2'h2) ? LVL2 : LVL3;

   // Receive side fires at or above, transmit side at or below
   assign hit = AT_ABOVE ? (level >= limit) : (level <= limit);

endmodule : fifo_level_cmp

// ===== hw/char_timeout_timer.sv
// Counts idle character times while the receive FIFO holds data
`timescale 1ns/1ps
`include "uart_irq_regs.svh"
module char_timeout_timer
   import uart_irq_pkg::*;
(
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic ce,
   input  wire logic enable,
   input  wire logic restart,
   input  wire logic charTick,
   input  wire logic notEmpty,
   output logic      expired_ff
);

   logic [2:0] count_ff;
   wire  logic [2:0] nxt_count;
   wire  logic       atLimit;

   assign atLimit = (count_ff == `UART_TIMEOUT_CHARS);
   assign nxt_count = (restart || !enable || !notEmpty) ? 3'h0 :
                      (charTick && !atLimit) ? count_ff + 3'h1 :
                      count_ff;

   // RULE5 idle character count
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         count_ff   <= 3'h0;
         expired_ff <= 1'b0;
      end else if (ce) begin
         count_ff   <= nxt_count;
         expired_ff <= (nxt_count == `UART_TIMEOUT_CHARS);
      end
   end

   a_timeout_needs_idle: assert property ( // RULE5
      @(posedge mclk) disable iff (!arst_n)
      $rose(expired_ff) |-> $past(count_ff) == 3'h3)
      else $error("timeout raised without three idle ticks before");

endmodule : char_timeout_timer

// ===== hw/uart_irq_id_fifo_ctrl.sv
// Interrupt identity and FIFO control of the serial port, APB slave
//
// What this block does
// RULE1 - Identity bits 7:6 read 00 with FIFOs off, 11 with FIFOs on.
// RULE2 - Four-bit ID shows highest pending source; resets to 0001.
// RULE3 - Line status, top priority, on errors; cleared by status or FIFO read.
// RULE4 - Receive data on arrival or trigger level; cleared by read or drop.
// RULE5 - Timeout after 4 idle character times with data; cleared by read.
// RULE6 - Transmit empty on empty holding, or at/below threshold in mode.
// RULE7 - Transmit empty clears on identity read, holding write (outside threshold mode), or refill.
// RULE8 - Modem status on modem input changes; cleared by modem status read.
// RULE9 - With auto flow control, clear-to-send change raises no interrupt.
// RULE10 - Line control write while busy raises busy; status read clears it.
// RULE11 - Receive trigger field 7:6 picks 1, quarter, half, two less.
// RULE12 - In auto flow control, request-to-send drops at receive trigger.
// RULE13 - Receive DMA request (active low) follows the receive trigger with FIFOs on, else receive not empty.
// RULE14 - Transmit threshold field 5:4 picks empty, 2, quarter, half.
// RULE15 - Transmit DMA request (active low) follows the transmit threshold in threshold mode, else holding empty.
// RULE16 - Control bit 2 clears transmit FIFO and its DMA request; self-clears.
// RULE17 - Control bit 1 clears receive FIFO and its DMA request; self-clears.
// RULE18 - Control bit 0 enables both FIFOs; any change resets both.
// RULE19 - Line status interrupt only while its enable bit is set; the bit gates only the setting, so a pending one stays after it clears.
// RULE20 - Enable register bit 7 selects programmable threshold mode while FIFOs are enabled.
// RULE21 - Offset 0x08 reads identity and writes FIFO control.
// RULE22 - FIFO state field follows the last written FIFO enable bit.
`timescale 1ns/1ps
`include "uart_irq_regs.svh"
module uart_irq_id_fifo_ctrl
   import uart_irq_pkg::*;
#(
   parameter bit LEGACY_COMPATIBLE = 1'b0
) (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata_ff,
   output logic             pready_ff,
   output logic             pslverr_ff,
   input  wire logic        lineError,
   input  wire logic        lsrRead,
   input  wire logic        rbrRead,
   input  wire logic        rxPush,
   input  wire logic        rxPop,
   input  wire logic [4:0]  rxLevel,
   input  wire logic        charTick,
   input  wire logic        holdWrite,
   input  wire logic        txHoldEmpty,
   input  wire logic [4:0]  txLevel,
   input  wire logic        ctsDelta,
   input  wire logic        dsrDelta,
   input  wire logic        riDelta,
   input  wire logic        dcdDelta,
   input  wire logic        msrRead,
   input  wire logic        afcEnable,
   input  wire logic        rtsRequest,
   input  wire logic        lineCtlWrite,
   input  wire logic        portBusy,
   input  wire logic        statusRead,
   output logic             intrPending_ff,
   output logic             rtsOut_n_ff,
   output logic             dmaRxReq_n_ff,
   output logic             dmaTxReq_n_ff,
   output logic             rxFifoClear_ff,
   output logic             txFifoClear_ff,
   output logic             fifoEnable_ff
);

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   logic [7:0]    enableReg_ff;
   level_sel_type rxTrig_ff;
   level_sel_type txThr_ff;
   irq_id_type    idCode_ff;
   logic          lsPend_ff;
   logic          rdaFlag_ff;
   logic          threPend_ff;
   logic          threCondPrev_ff;
   logic          msPend_ff;
   logic          busyPend_ff;

   wire logic       accessWait;
   wire logic       xferDone;
   wire logic       hitEnable;
   wire logic       hitId;
   wire logic       mapped;
   wire logic       wrEnable;
   wire logic       wrControl;
   wire logic       idRead;
   wire logic [31:0] rdMux;
   wire logic       ieRda;
   wire logic       ieThre;
   wire logic       ieLs;
   wire logic       ieMs;
   wire logic       thMode;
   wire logic       enToggle;
   wire logic       nxt_txClear;
   wire logic       nxt_rxClear;
   wire logic       rxAtTrig;
   wire logic       txAtThr;
   wire logic       toPend;
   wire logic       lsSet;
   wire logic       lsClr;
   wire logic       rdaPend;
   wire logic       threCond;
   wire logic       threSet;
   wire logic       threClr;
   wire logic       msSet;
   wire logic       busySet;
   wire logic       anyPend;
   wire irq_id_type nxt_idCode;
   wire logic       nxt_dmaRx_n;
   wire logic       nxt_dmaTx_n;
   wire logic       nxt_rts_n;

   // One-wait answer, one cycle late so prdata can come from a flop
   assign accessWait = psel && penable && !pready_ff;
   assign xferDone   = psel && penable && pready_ff;

   // RULE21 shared offset decode
   assign hitEnable = (paddr == `UART_INTEN_OFS);
   assign hitId     = (paddr == `UART_IDENT_OFS);
   assign mapped    = hitEnable || hitId;
   assign wrEnable  = xferDone && pwrite && hitEnable;
   assign wrControl = xferDone && pwrite && hitId;
   assign idRead    = xferDone && !pwrite && hitId;

   // RULE1 fifo state field
   // RULE22 follows enable
   assign rdMux = !pwrite && hitEnable ? {24'h0, enableReg_ff} :
                  !pwrite && hitId     ? {24'h0, {2{fifoEnable_ff}},
                                          2'h0, idCode_ff} : 32'h0;

   assign ieRda  = enableReg_ff[`UART_INTEN_RDA_BIT];
   assign ieThre = enableReg_ff[`UART_INTEN_THRE_BIT];
   assign ieLs   = enableReg_ff[`UART_INTEN_LS_BIT];
   assign ieMs   = enableReg_ff[`UART_INTEN_MS_BIT];
   // RULE20 threshold mode select
   assign thMode = enableReg_ff[`UART_INTEN_THM_BIT] && fifoEnable_ff;

   // RULE18 enable change resets
   assign enToggle = wrControl &&
                     (pwdata[`UART_FCTL_EN_BIT] != fifoEnable_ff);
   // RULE16 transmit clear
   assign nxt_txClear = wrControl &&
                        (pwdata[`UART_FCTL_TXCLR_BIT] || enToggle);
   // RULE17 receive clear
   assign nxt_rxClear = wrControl &&
                        (pwdata[`UART_FCTL_RXCLR_BIT] || enToggle);

   // RULE11 receive trigger levels
   fifo_level_cmp #(
      .LVL0     (`UART_RX_TRIG0),
      .LVL1     (`UART_RX_TRIG1),
      .LVL2     (`UART_RX_TRIG2),
      .LVL3     (`UART_RX_TRIG3),
      .AT_ABOVE (1'b1)
   ) u_rx_cmp (
      .sel   (rxTrig_ff),
      .level (rxLevel),
      .hit   (rxAtTrig)
   );

   // RULE14 transmit thresholds
   fifo_level_cmp #(
      .LVL0     (`UART_TX_THR0),
      .LVL1     (`UART_TX_THR1),
      .LVL2     (`UART_TX_THR2),
      .LVL3     (`UART_TX_THR3),
      .AT_ABOVE (1'b0)
   ) u_tx_cmp (
      .sel   (txThr_ff),
      .level (txLevel),
      .hit   (txAtThr)
   );

   // RULE5 character timeout
   char_timeout_timer u_timeout (
      .mclk       (mclk),
      .arst_n     (arst_n),
      .ce         (ce),
      .enable     (fifoEnable_ff && ieRda),
      .restart    (rxPush || rxPop || rbrRead || rxFifoClear_ff),
      .charTick   (charTick),
      .notEmpty   (rxLevel != 5'd0),
      .expired_ff (toPend)
   );

   // RULE3 line status errors
   // RULE19 gated by enable
   assign lsSet = lineError && ieLs;
   assign lsClr = lsrRead || rxPop || rbrRead;

   // RULE4 receive data source
   assign rdaPend = ieRda && (fifoEnable_ff ? rxAtTrig : rdaFlag_ff);

   // RULE6 transmit empty condition
   assign threCond = thMode ? txAtThr : txHoldEmpty;
   assign threSet  = ieThre && threCond && !threCondPrev_ff;
   // RULE7 transmit empty clear
   assign threClr  = (idRead && prdata_ff[3:0] == ID_THRE) ||
                     (holdWrite && !thMode) || !threCond || !ieThre;

   // RULE8 modem changes
   // RULE9 no cts interrupt under flow control
   assign msSet = ieMs && ((ctsDelta && !afcEnable) ||
                           dsrDelta || riDelta || dcdDelta);

   // RULE10 busy detect
   assign busySet = !LEGACY_COMPATIBLE && lineCtlWrite && portBusy;

   // RULE2 priority encode
   assign anyPend = lsPend_ff || rdaPend || toPend || threPend_ff ||
                    msPend_ff || busyPend_ff;
   assign nxt_idCode = lsPend_ff   ? ID_LINE    :
                       rdaPend     ? ID_RDA     :
                       toPend      ? ID_TIMEOUT :
                       threPend_ff ? ID_THRE    :
                       msPend_ff   ? ID_MODEM   :
                       busyPend_ff ? ID_BUSY    : ID_NONE;

   // RULE13 receive DMA request
   assign nxt_dmaRx_n = nxt_rxClear || rxFifoClear_ff ||
                        !(fifoEnable_ff ? rxAtTrig : rxLevel != 5'd0);
   // RULE15 transmit DMA request
   assign nxt_dmaTx_n = nxt_txClear || txFifoClear_ff ||
                        !(thMode ? txAtThr : txHoldEmpty);
   // RULE12 flow control stop
   assign nxt_rts_n = afcEnable ? (rxAtTrig || !rtsRequest) : !rtsRequest;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0;
         pslverr_ff <= 1'b0;
      end else if (ce) begin
         pready_ff <= accessWait;
         if (accessWait) begin
            prdata_ff  <= rdMux;
            pslverr_ff <= !mapped;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         enableReg_ff  <= `UART_INTEN_RESET;
         fifoEnable_ff <= `UART_FCTL_EN_RESET;
         rxTrig_ff     <= 2'h0;
         txThr_ff      <= 2'h0;
      end else if (ce) begin
         if (wrEnable) begin
            enableReg_ff <= pwdata[7:0] & `UART_INTEN_MASK;
         end
         if (wrControl) begin
            fifoEnable_ff <= pwdata[`UART_FCTL_EN_BIT];
            rxTrig_ff     <= pwdata[`UART_FCTL_RXT_LSB +: 2];
            txThr_ff      <= pwdata[`UART_FCTL_TXT_LSB +: 2];
         end
      end
   end

   // Event flags: a set in the clearing cycle wins
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lsPend_ff       <= 1'b0;
         rdaFlag_ff      <= 1'b0;
         threPend_ff     <= 1'b0;
         threCondPrev_ff <= 1'b0;
         msPend_ff       <= 1'b0;
         busyPend_ff     <= 1'b0;
      end else if (ce) begin
         lsPend_ff       <= lsSet || (lsPend_ff && !lsClr);
         rdaFlag_ff      <= rxPush || (rdaFlag_ff && !rbrRead);
         threPend_ff     <= threSet || (threPend_ff && !threClr);
         threCondPrev_ff <= threCond && ieThre;
         msPend_ff       <= msSet || (msPend_ff && !msrRead);
         busyPend_ff     <= busySet || (busyPend_ff && !statusRead);
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         idCode_ff      <= ID_NONE;
         intrPending_ff <= 1'b0;
         txFifoClear_ff <= 1'b0;
         rxFifoClear_ff <= 1'b0;
         dmaRxReq_n_ff  <= 1'b1;
         dmaTxReq_n_ff  <= 1'b1;
         rtsOut_n_ff    <= 1'b1;
      end else if (ce) begin
         idCode_ff      <= nxt_idCode;
         intrPending_ff <= anyPend;
         txFifoClear_ff <= nxt_txClear;
         rxFifoClear_ff <= nxt_rxClear;
         dmaRxReq_n_ff  <= nxt_dmaRx_n;
         dmaTxReq_n_ff  <= nxt_dmaTx_n;
         rtsOut_n_ff    <= nxt_rts_n;
      end
   end

   a_apb_one_wait: assert property (
      ce && accessWait |=> pready_ff && prdata_ff == $past(rdMux))
      else $error("apb answer not one cycle after access");

   a_fifo_state_read: assert property ( // RULE1
      idRead |-> prdata_ff[7:6] == {2{fifoEnable_ff}})
      else $error("fifo state bits disagree with enable");

   a_id_none_idle: assert property ( // RULE2
      ce && !anyPend |=> idCode_ff == ID_NONE && !intrPending_ff)
      else $error("id not none while nothing pending");

   a_line_status_top: assert property ( // RULE3
      ce && lsPend_ff |=> idCode_ff == ID_LINE)
      else $error("line status not reported first");

   a_line_status_clr: assert property ( // RULE3
      ce && lsPend_ff && rxPop && !lsSet |=> !lsPend_ff)
      else $error("line status not cleared by fifo read");

   a_rda_at_trigger: assert property ( // RULE4
      ce && fifoEnable_ff && ieRda && rxAtTrig && !lsPend_ff
      |=> idCode_ff == ID_RDA)
      else $error("receive trigger not reported");

   a_thre_id_clear: assert property ( // RULE7
      ce && idRead && prdata_ff[3:0] == ID_THRE && !threSet
      |=> !threPend_ff)
      else $error("identity read did not clear transmit empty");

   a_cts_no_irq: assert property ( // RULE9
      ce && afcEnable && ctsDelta && !dsrDelta && !riDelta &&
      !dcdDelta && !msPend_ff |=> !msPend_ff)
      else $error("cts change raised modem irq under flow control");

   a_busy_raise: assert property ( // RULE10
      ce && busySet |=> busyPend_ff ##1 (idCode_ff != ID_NONE))
      else $error("busy write not flagged");

   a_rts_stop: assert property ( // RULE12
      ce && afcEnable && rxAtTrig |=> rtsOut_n_ff)
      else $error("rts still asserted at receive trigger");

   a_tx_clear_dma: assert property ( // RULE16
      ce && wrControl && pwdata[`UART_FCTL_TXCLR_BIT]
      |=> txFifoClear_ff && dmaTxReq_n_ff ##1
      (!txFifoClear_ff || $past(nxt_txClear)) && dmaTxReq_n_ff)
      else $error("transmit clear pulse or dma drop wrong");

   a_en_toggle_both: assert property ( // RULE18
      ce && enToggle |=> rxFifoClear_ff && txFifoClear_ff &&
      dmaRxReq_n_ff)
      else $error("enable change did not clear both fifos");

   c_line_status: cover property (ce && lsSet ##[1:20] lsClr);
   c_timeout_seen: cover property (idCode_ff == ID_TIMEOUT);
   c_thre_by_read: cover property (idRead && prdata_ff[3:0] == ID_THRE);
   c_busy_seen: cover property (idCode_ff == ID_BUSY);

endmodule : uart_irq_id_fifo_ctrl

// ===== dv/uart_side_model.sv
// Behavioural model of the receiver, transmitter and modem logic
`timescale 1ns/1ps
module uart_side_model (
   input  wire logic        mclk,
   output logic      [13:0] ev
);
   initial begin
      ev = '0;
   end

   // Event strobes last exactly one clock, as the real logic makes them
   task automatic fire(input logic [13:0] m);
      @(posedge mclk) ev <= m;
      @(posedge mclk) ev <= '0;
   endtask : fire
endmodule : uart_side_model

// ===== dv/tb_top.sv
// Self-checking bench for the interrupt identity and FIFO control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errTotal++; \
   $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top
   import uart_irq_pkg::*;
;
   localparam logic [11:0] IE_ADR = 12'h004;
   localparam logic [11:0] ID_ADR = 12'h008;
   localparam int LERR = 0, LSRD = 1, RBRD = 2, PUSH = 3, TICK = 5;
   localparam int HWR = 6, CTS = 7, MSRD = 11, LCWR = 12, STRD = 13;
   logic        mclk = 1'b0;
   logic        arst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, intrPending, rtsOut_n;
   logic        dmaRxReq_n, dmaTxReq_n, rxClr, txClr, fifoEn;
   logic [13:0] ev;
   // Transmit FIFO starts full so no empty condition is pending
   logic [4:0]  rxLevel = 5'h00;
   logic [4:0]  txLevel = 5'h10;
   logic        txHoldEmpty = 1'b0;
   logic        afcEnable = 1'b0;
   logic        rtsRequest = 1'b1;
   logic        portBusy = 1'b0;
   logic [33:0] expQ[$];
   logic [33:0] q;
   int          errTotal = 0;
   int          compares = 0;
   int          seed = 32'h672469FF;
   int          v;
   logic [4:0]  trigTab[4] = '{5'h01, 5'h04, 5'h08, 5'h0E};
   logic [4:0]  txTab[4] = '{5'h00, 5'h02, 5'h04, 5'h08};

   always #2.5 mclk = ~mclk;

   uart_side_model side_u (.mclk(mclk), .ev(ev));

   uart_irq_id_fifo_ctrl dut_u (.mclk(mclk), .arst_n(arst_n), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata_ff(prdata), .pready_ff(pready),
      .pslverr_ff(pslverr), .lineError(ev[0]), .lsrRead(ev[1]),
      .rbrRead(ev[2]), .rxPush(ev[3]), .rxPop(ev[4]), .rxLevel(rxLevel),
      .charTick(ev[5]), .holdWrite(ev[6]), .txHoldEmpty(txHoldEmpty),
      .txLevel(txLevel), .ctsDelta(ev[7]), .dsrDelta(ev[8]),
      .riDelta(ev[9]), .dcdDelta(ev[10]), .msrRead(ev[11]),
      .afcEnable(afcEnable), .rtsRequest(rtsRequest), .lineCtlWrite(ev[12]),
      .portBusy(portBusy), .statusRead(ev[13]), .intrPending_ff(intrPending),
      .rtsOut_n_ff(rtsOut_n), .dmaRxReq_n_ff(dmaRxReq_n),
      .dmaTxReq_n_ff(dmaTxReq_n), .rxFifoClear_ff(rxClr),
      .txFifoClear_ff(txClr), .fifoEnable_ff(fifoEn));

   task automatic testDone;
      $display("compares %0d mismatches %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : testDone

   // One APB transfer; the expected answer is noted for the monitor
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      int n;
      n = 0;
      expQ.push_back({~w, e});
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         errTotal++;
         testDone();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask : rd

   task automatic hit(input int b);
      side_u.fire(14'h0001 << b);
   endtask : hit

   // Compares each answer with the oldest noted expectation
   always @(posedge mclk) begin
      if (pready === 1'b1) begin
         q = expQ.pop_front();
         `CHK("pslverr", q[32], pslverr)
         if (q[33]) `CHK("prdata", q[31:0], prdata)
      end
   end

   initial begin
      #400000;
      errTotal++;
      testDone();
   end

   initial begin
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      rd(ID_ADR, 32'h01);
      rd(IE_ADR, 32'h00);
      `CHK("rtsOut_n", 1'b0, rtsOut_n)
      apb(1'b0, 12'h0F0, 32'h0, {1'b1, 32'h0});
      wr(IE_ADR, 32'hFF);
      rd(IE_ADR, 32'h8F);
      wr(IE_ADR, 32'h00);
      wr(ID_ADR, 32'h01);
      #1 `CHK("rxClr", 1'b1, rxClr)
      `CHK("txClr", 1'b1, txClr)
      @(posedge mclk) #1 `CHK("rxClr", 1'b0, rxClr)
      `CHK("fifoEn", 1'b1, fifoEn)
      rd(ID_ADR, 32'hC1);
      $display("reset and map test done");
      wr(IE_ADR, 32'h04);
      hit(LERR);
      rd(ID_ADR, 32'hC6);
      hit(LSRD);
      rd(ID_ADR, 32'hC1);
      hit(LERR);
      hit(4);
      rd(ID_ADR, 32'hC1);
      wr(IE_ADR, 32'h01);
      hit(LERR);
      rd(ID_ADR, 32'hC1);
      $display("line status test done");
      afcEnable <= 1'b1;
      for (int t = 0; t < 4; t++) begin
         wr(ID_ADR, {24'h0, 2'(t), 6'h01});
         for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? trigTab[t] - 1 : (k == 1) ? trigTab[t] :
                $unsigned($random(seed)) % 17;
            @(posedge mclk) rxLevel <= 5'(v);
            rd(ID_ADR, (v >= trigTab[t]) ? 32'hC4 : 32'hC1);
            `CHK("dmaRxReq_n", 1'(v < trigTab[t]), dmaRxReq_n)
            `CHK("rtsOut_n", 1'(v >= trigTab[t]), rtsOut_n)
         end
      end
      afcEnable <= 1'b0;
      rxLevel <= 5'h00;
      wr(ID_ADR, 32'h00);
      rd(ID_ADR, 32'h01);
      hit(PUSH);
      rd(ID_ADR, 32'h04);
      hit(RBRD);
      rd(ID_ADR, 32'h01);
      wr(ID_ADR, 32'hC1);
      rxLevel <= 5'h01;
      repeat (3) hit(TICK);
      rd(ID_ADR, 32'hC1);
      hit(TICK);
      rd(ID_ADR, 32'hCC);
      hit(RBRD);
      rd(ID_ADR, 32'hC1);
      rxLevel <= 5'h00;
      $display("receive test done");
      wr(IE_ADR, 32'h02);
      txHoldEmpty <= 1'b1;
      rd(ID_ADR, 32'hC2);
      rd(ID_ADR, 32'hC1);
      txHoldEmpty <= 1'b0;
      @(posedge mclk) txHoldEmpty <= 1'b1;
      rd(ID_ADR, 32'hC2);
      hit(HWR);
      rd(ID_ADR, 32'hC1);
      txHoldEmpty <= 1'b0;
      wr(IE_ADR, 32'h82);
      for (int t = 0; t < 4; t++) begin
         wr(ID_ADR, {24'h0, 2'b00, 2'(t), 4'h1});
         txLevel <= txTab[t] + 5'h01;
         rd(ID_ADR, 32'hC1);
         `CHK("dmaTxReq_n", 1'b1, dmaTxReq_n)
         txLevel <= txTab[t];
         rd(ID_ADR, 32'hC2);
         `CHK("dmaTxReq_n", 1'b0, dmaTxReq_n)
      end
      wr(ID_ADR, 32'h35);
      #1 `CHK("txClr", 1'b1, txClr)
      `CHK("dmaTxReq_n", 1'b1, dmaTxReq_n)
      txLevel <= 5'h10;
      rd(ID_ADR, 32'hC1);
      $display("transmit test done");
      wr(IE_ADR, 32'h08);
      afcEnable <= 1'b1;
      hit(CTS);
      rd(ID_ADR, 32'hC1);
      afcEnable <= 1'b0;
      for (int b = CTS; b < MSRD; b++) begin
         hit(b);
         rd(ID_ADR, 32'hC0);
         hit(MSRD);
         rd(ID_ADR, 32'hC1);
      end
      portBusy <= 1'b1;
      side_u.fire(14'h0001 << LCWR | 14'h0001 << 8);
      rd(ID_ADR, 32'hC0);
      hit(MSRD);
      rd(ID_ADR, 32'hC7);
      `CHK("intrPending", 1'b1, intrPending)
      hit(STRD);
      rd(ID_ADR, 32'hC1);
      `CHK("intrPending", 1'b0, intrPending)
      portBusy <= 1'b0;
      hit(LCWR);
      rd(ID_ADR, 32'hC1);
      $display("modem and busy test done");
      testDone();
   end
endmodule : tb_top
